// File: design/irq_sig_pkg.sv
// Constants shared by the interrupt signalling logic
package irq_sig_pkg;
    // Clock rate in kHz
    localparam int unsigned CLK_KHZ = 25000;
    // Timing figures in microseconds
    localparam int unsigned PULSE_US = 100;
    localparam int unsigned GAP_US = 100;
    localparam int unsigned CFG_FILT_US = 10;
    // Derived cycle counts
    localparam int unsigned PULSE_CYC = PULSE_US * CLK_KHZ / 1000;
    localparam int unsigned GAP_CYC = GAP_US * CLK_KHZ / 1000;
    localparam int unsigned CFG_FILT_CYC = CFG_FILT_US * CLK_KHZ / 1000;
    // Interrupt class select reset value: wake only
    localparam logic CLASS_RST = 1'b0;
    // Mode encodings
    localparam logic [1:0] MODE_INIT = 2'h0;
    localparam logic [1:0] MODE_NORMAL = 2'h1;
    localparam logic [1:0] MODE_STOP = 2'h2;
    localparam logic [1:0] MODE_OTHER = 2'h3;
    // Pulse generator states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PULSE = 3'b010,
        ST_GAP = 3'b100
    } pulse_state_t;
endpackage

// File: design/irq_sync2.sv
// Two flip-flop synchroniser for the interrupt pin input
`timescale 1ns/1ps
`default_nettype none
module irq_sync2 (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Data
    input wire logic d,
    output logic q
);
    logic meta_r;
    logic meta_nxt;
    logic q_r;
    logic q_nxt;

    // Shift one stage per enabled clock
    always_comb begin
        meta_nxt = clk_en ? d : meta_r;
        q_nxt = clk_en ? meta_r : q_r;
    end

    // Pin idles high while the block drives it, so reset to one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b1;
            q_r <= 1'b1;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule // irq_sync2
`default_nettype wire

// File: design/irq_cfg_filter.sv
// Glitch filter that samples the configuration level on the interrupt pin
`timescale 1ns/1ps
`default_nettype none
module irq_cfg_filter #(
    parameter int unsigned FILT_CYC = irq_sig_pkg::CFG_FILT_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Synchronised pin level and sampling enable
    input wire logic level,
    input wire logic active,
    // Filtered level
    output logic filt_level
);
    localparam int CW = $clog2(FILT_CYC + 1);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic filt_r;
    logic filt_nxt;

    initial begin
        if (FILT_CYC < 1) $error("filter count must be at least one");
    end

    // Accept a new level only after it held for the whole filter span
    always_comb begin
        cnt_nxt = cnt_r;
        filt_nxt = filt_r;
        if (clk_en && active) begin
            if (level == filt_r) begin
                cnt_nxt = '0;
            end else if (cnt_r == CW'(FILT_CYC - 1)) begin
                cnt_nxt = '0;
                filt_nxt = level;
            end else begin
                cnt_nxt = cnt_r + CW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            filt_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            filt_r <= filt_nxt;
        end
    end

    assign filt_level = filt_r;

    // Short glitch never moves the output
    a_glitch_rejected: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && active && level != filt_r && cnt_r == '0) ##1 (level == filt_r) |=> $stable(filt_r))
        else $error("short level change passed the filter");
endmodule // irq_cfg_filter
`default_nettype wire

// File: design/sbc_interrupt_signalling.sv
// Interrupt pulse generation, event latching and config pin sampling
// What this block does
// - In Normal or Stop, an event drives the line low for 100 us.
// - Line stays high at least 100 us between two pulses.
// - Pulsing never changes the operating mode.
// - Class bit zero selects wake only; one adds failures.
// - Wake events interrupt only when their source is wake enabled.
// - Global class also interrupts on new non-forcing failure events.
// - Pin level status never interrupts and is not latched.
// - Undervoltage, watchdog, short, thermal level two, general failure never interrupt.
// - Power-on reset flag and device status bits never interrupt.
// - Entering Stop with wake status still set issues a pulse.
// - Visible status registers update at each pulse falling edge.
// - Latched events stay set until host reads and clears them, except unpublished ones, which are dropped on leaving Normal/Stop.
// - In Init the pin is an input sampled for configuration.
// - Configuration sampling rejects level changes shorter than about 10 us.
`timescale 1ns/1ps
`default_nettype none
module sbc_interrupt_signalling #(
    parameter int unsigned WAKE_W = 16,
    parameter int unsigned FAIL_W = 16,
    parameter int unsigned LVL_W = 8,
    parameter int unsigned PULSE_CYC = irq_sig_pkg::PULSE_CYC,
    parameter int unsigned GAP_CYC = irq_sig_pkg::GAP_CYC,
    parameter int unsigned CFG_FILT_CYC = irq_sig_pkg::CFG_FILT_CYC
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Operating mode and Stop command strobe
    input wire logic [1:0] mode,
    input wire logic stop_cmd,
    // Class select
    input wire logic class_global,
    // Wake events (one-cycle pulses) and wake source enables
    input wire logic [WAKE_W-1:0] wake_evt,
    input wire logic [WAKE_W-1:0] wake_src_en,
    // Failure events, and mask of bits that force Restart or Fail-Safe
    input wire logic [FAIL_W-1:0] fail_evt,
    input wire logic [FAIL_W-1:0] fail_forcing_mask,
    // Pin levels, shown live
    input wire logic [LVL_W-1:0] pin_level_in,
    // Host read-and-clear strobes, one bit per status bit
    input wire logic [WAKE_W-1:0] wake_clr,
    input wire logic [FAIL_W-1:0] fail_clr,
    // Status visible to the host
    output logic [WAKE_W-1:0] wake_status,
    output logic [FAIL_W-1:0] fail_status,
    output logic [LVL_W-1:0] pin_level_status,
    // Interrupt pin, push/pull
    input wire logic int_pin_i,
    output logic int_pin_o,
    output logic int_pin_oe,
    // Filtered configuration level sampled in Init
    output logic cfg_level
);
    localparam int PW = $clog2((PULSE_CYC > GAP_CYC ? PULSE_CYC : GAP_CYC) + 1);

    initial begin
        if (PULSE_CYC < 1 || GAP_CYC < 1) $error("pulse and gap counts must be at least one");
        if (WAKE_W < 1 || FAIL_W < 1 || LVL_W < 1) $error("status widths must be at least one");
        if (WAKE_W > 32 || FAIL_W > 32) $error("status widths above 32 exceed the trigger reduction");
        if (GAP_CYC < 8) $error("gap count must be at least eight");
    end

    // OR reduction of a status or event vector, zero-extended to 32 bits
    function automatic logic any_bit(input logic [31:0] v);
        any_bit = |v;
    endfunction

    logic signal_mode;
    assign signal_mode = (mode == irq_sig_pkg::MODE_NORMAL) || (mode == irq_sig_pkg::MODE_STOP);

    // Internal latches and shadow (host-visible) copies
    logic [WAKE_W-1:0] wake_lat_r, wake_lat_nxt, wake_vis_r, wake_vis_nxt;
    logic [FAIL_W-1:0] fail_lat_r, fail_lat_nxt, fail_vis_r, fail_vis_nxt;
    logic [LVL_W-1:0] lvl_r, lvl_nxt;
    logic pend_r, pend_nxt;
    logic int_low_r, int_low_nxt;
    logic [PW-1:0] cnt_r, cnt_nxt;
    irq_sig_pkg::pulse_state_t st_r, st_nxt;
    logic trig_wake, trig_fail, trig_stop, trig, fall;
    logic [FAIL_W-1:0] fail_allowed;

    // Forcing failures are excluded; power-on and device status never arrive here
    assign fail_allowed = fail_evt & ~fail_forcing_mask;
    assign trig_wake = any_bit(32'(wake_evt & wake_src_en));
    assign trig_fail = class_global && any_bit(32'(fail_allowed));
    assign trig_stop = stop_cmd && (any_bit(32'(wake_vis_r)) || any_bit(32'(wake_lat_r)));
    assign trig = trig_wake || trig_fail || trig_stop;
    assign fall = clk_en && (st_nxt == irq_sig_pkg::ST_PULSE) && (st_r != irq_sig_pkg::ST_PULSE);

    // Pulse sequencer; mode is only read, never driven
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        pend_nxt = pend_r;
        int_low_nxt = int_low_r;
        if (clk_en) begin
            if (trig) pend_nxt = 1'b1;
            case (st_r)
                irq_sig_pkg::ST_IDLE: begin
                    if ((trig || pend_r) && signal_mode) begin
                        st_nxt = irq_sig_pkg::ST_PULSE;
                        cnt_nxt = '0;
                        pend_nxt = 1'b0;
                        int_low_nxt = 1'b1;
                    end
                end
                irq_sig_pkg::ST_PULSE: begin
                    if (cnt_r == PW'(PULSE_CYC - 1)) begin
                        st_nxt = irq_sig_pkg::ST_GAP;
                        cnt_nxt = '0;
                        int_low_nxt = 1'b0;
                    end else begin
                        cnt_nxt = cnt_r + PW'(1);
                    end
                end
                irq_sig_pkg::ST_GAP: begin
                    if (cnt_r == PW'(GAP_CYC - 1)) begin
                        st_nxt = irq_sig_pkg::ST_IDLE;
                        cnt_nxt = '0;
                    end else begin
                        cnt_nxt = cnt_r + PW'(1);
                    end
                end
                default: begin
                    st_nxt = irq_sig_pkg::ST_IDLE;
                    int_low_nxt = 1'b0;
                end
            endcase
            // Leaving the signalling modes releases the line at once
            if (!signal_mode && st_r == irq_sig_pkg::ST_PULSE) begin
                st_nxt = irq_sig_pkg::ST_GAP;
                cnt_nxt = '0;
                int_low_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= irq_sig_pkg::ST_IDLE;
            cnt_r <= '0;
            pend_r <= 1'b0;
            int_low_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            pend_r <= pend_nxt;
            int_low_r <= int_low_nxt;
        end
    end

    // Status latching; a new event wins over a clear in the same cycle
    always_comb begin
        wake_lat_nxt = wake_lat_r;
        fail_lat_nxt = fail_lat_r;
        wake_vis_nxt = wake_vis_r;
        fail_vis_nxt = fail_vis_r;
        lvl_nxt = lvl_r;
        if (clk_en) begin
            wake_lat_nxt = wake_lat_r | wake_evt;
            fail_lat_nxt = fail_lat_r | fail_evt;
            wake_vis_nxt = wake_vis_r & ~wake_clr;
            fail_vis_nxt = fail_vis_r & ~fail_clr;
            lvl_nxt = pin_level_in;
            if (fall) begin
                // Publish collected events at the falling edge
                wake_vis_nxt = wake_vis_nxt | wake_lat_r | wake_evt;
                fail_vis_nxt = fail_vis_nxt | fail_lat_r | fail_evt;
                wake_lat_nxt = '0;
                fail_lat_nxt = '0;
            end else if (!signal_mode) begin
                // No pulses outside Normal/Stop, so publish directly
                wake_vis_nxt = wake_vis_nxt | wake_evt;
                fail_vis_nxt = fail_vis_nxt | fail_evt;
                wake_lat_nxt = '0;
                fail_lat_nxt = '0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_lat_r <= '0;
            fail_lat_r <= '0;
            wake_vis_r <= '0;
            fail_vis_r <= '0;
            lvl_r <= '0;
        end else begin
            wake_lat_r <= wake_lat_nxt;
            fail_lat_r <= fail_lat_nxt;
            wake_vis_r <= wake_vis_nxt;
            fail_vis_r <= fail_vis_nxt;
            lvl_r <= lvl_nxt;
        end
    end

    assign wake_status = wake_vis_r;
    assign fail_status = fail_vis_r;
    assign pin_level_status = lvl_r;

    // Pin drive: released in Init so the strap can be read
    assign int_pin_oe = (mode != irq_sig_pkg::MODE_INIT);
    assign int_pin_o = ~int_low_r;

    // Configuration level path
    logic pin_sync;
    irq_sync2 u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .d(int_pin_i),
        .q(pin_sync)
    );

    irq_cfg_filter #(
        .FILT_CYC(CFG_FILT_CYC)
    ) u_filt (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .level(pin_sync),
        .active(mode == irq_sig_pkg::MODE_INIT),
        .filt_level(cfg_level)
    );

    // Assertion helpers: pulse start, pulse end and the quiet span after it
    sequence s_fall;
        $rose(int_low_r);
    endsequence
    sequence s_release;
        $fell(int_low_r);
    endsequence
    sequence s_high_held;
        !int_low_r [*8];
    endsequence

    // Pulse timing; width is held against the counter, a full-width repetition would be far too long
    a_pulse_low_held: assert property (@(posedge clk) disable iff (!rst_n)
        s_release |-> ($past(cnt_r) == PW'(PULSE_CYC - 1)) || !$past(signal_mode))
        else $error("pulse ended too early");
    a_pulse_released: assert property (@(posedge clk) disable iff (!rst_n)
        (int_low_r && cnt_r == PW'(PULSE_CYC - 1) && clk_en) |=> !int_low_r)
        else $error("pulse not released at its width");
    a_gap_high: assert property (@(posedge clk) disable iff (!rst_n)
        s_release |-> s_high_held)
        else $error("gap too short");
    a_gap_entered: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(int_low_r) |-> st_r == irq_sig_pkg::ST_GAP)
        else $error("release without gap");
    a_no_pulse_off_mode: assert property (@(posedge clk) disable iff (!rst_n)
        s_fall |-> $past(signal_mode))
        else $error("pulse outside Normal or Stop");
    // Source selection and pending events
    a_disabled_wake_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == irq_sig_pkg::ST_IDLE && !pend_r && clk_en && !trig_fail && !trig_stop
         && ((wake_evt & wake_src_en) == '0)) |=> !int_low_r)
        else $error("pulse from disabled source");
    a_class_wake_only: assert property (@(posedge clk) disable iff (!rst_n)
        !class_global |-> !trig_fail)
        else $error("failure trigger in wake class");
    a_forcing_excluded: assert property (@(posedge clk) disable iff (!rst_n)
        ((fail_evt & ~fail_forcing_mask) == '0) |-> !trig_fail)
        else $error("forcing failure raised interrupt");
    a_stop_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && trig_stop) |=> pend_r || int_low_r || st_r != irq_sig_pkg::ST_IDLE)
        else $error("stop entry with wake status lost");
    a_pending_kept: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && trig && st_r == irq_sig_pkg::ST_GAP) |=> pend_r)
        else $error("event during gap dropped");
    a_pending_served: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && st_r == irq_sig_pkg::ST_IDLE && pend_r && signal_mode) |=> int_low_r)
        else $error("pending event not signalled after the gap");
    // Status publishing at the falling edge; status bits hold while no clear is applied
    a_publish_fall: assert property (@(posedge clk) disable iff (!rst_n)
        (fall && wake_lat_r != '0) |=> (wake_vis_r & $past(wake_lat_r)) == $past(wake_lat_r))
        else $error("status not published at falling edge");
    a_publish_fail: assert property (@(posedge clk) disable iff (!rst_n)
        (fall && fail_lat_r != '0) |=> (fail_vis_r & $past(fail_lat_r)) == $past(fail_lat_r))
        else $error("failure status not published at falling edge");
    a_status_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        (wake_vis_r != '0 && wake_clr == '0) |=> (wake_vis_r & $past(wake_vis_r)) == $past(wake_vis_r))
        else $error("wake status lost without clear");
    a_fail_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        (fail_vis_r != '0 && fail_clr == '0) |=> (fail_vis_r & $past(fail_vis_r)) == $past(fail_vis_r))
        else $error("failure status lost without clear");
    a_level_live: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en |=> pin_level_status == $past(pin_level_in))
        else $error("pin level status not following the pins");
    // Pin direction follows the mode
    a_init_released: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == irq_sig_pkg::MODE_INIT) |-> !int_pin_oe)
        else $error("pin driven in Init");
    a_oe_outside_init: assert property (@(posedge clk) disable iff (!rst_n)
        (mode != irq_sig_pkg::MODE_INIT) |-> int_pin_oe)
        else $error("pin not driven outside Init");
endmodule // sbc_interrupt_signalling
`default_nettype wire

// File: bench/host_side.sv
// Host side model: interrupt input, pulse timing monitor and config strap driver
`timescale 1ns/1ps
`default_nettype none
module host_side (
    // Clock
    input wire logic clk,
    // Pin as driven by the block
    input wire logic int_pin_o,
    input wire logic int_pin_oe,
    // Strap level the board applies while the block listens
    input wire logic strap_lvl,
    input wire logic strap_en,
    // Resolved pin and pulse statistics
    output logic int_wire,
    output int pulse_cnt,
    output int last_low,
    output int last_high
);
    int low_len;
    int high_len;
    logic prev_r;
    logic mon;
    // Released pin falls to the config pull-down, never a stale level
    assign int_wire = int_pin_oe ? int_pin_o : (strap_en ? strap_lvl : 1'b0);
    // Pulses count only while the block drives, so a strap level is no interrupt
    assign mon = int_pin_oe ? int_pin_o : 1'b1;
    initial begin
        pulse_cnt = 0;
        last_low = 0;
        last_high = 0;
        low_len = 0;
        high_len = 0;
        prev_r = 1'b1;
    end
    // Measure low and high spans of the interrupt line
    always @(posedge clk) begin
        if (prev_r === 1'b1 && mon === 1'b0) begin
            pulse_cnt <= pulse_cnt + 1;
            last_high <= high_len;
            low_len <= 1;
        end else if (prev_r === 1'b0 && mon === 1'b1) begin
            last_low <= low_len;
            high_len <= 1;
        end else begin
            low_len <= low_len + 1;
            high_len <= high_len + 1;
        end
        prev_r <= mon;
    end
endmodule // host_side
`default_nettype wire

// File: bench/sbc_interrupt_signalling_tb.sv
// Self-checking bench for the interrupt signalling block
`timescale 1ns/1ps
`default_nettype none
module sbc_interrupt_signalling_tb;
    localparam int PC = 10;
    localparam int GC = 10;
    localparam int FC = 4;
    logic clk, rst_n, stop_cmd, class_global, strap_lvl, strap_en, int_wire;
    logic [1:0] mode;
    logic [15:0] wake_evt, wake_src_en, fail_evt, fail_forcing_mask, wake_clr, fail_clr, wake_status, fail_status;
    logic [7:0] pin_level_in, pin_level_status;
    // Events collected by the block but not yet published
    logic [15:0] acc_w, acc_f;
    logic int_pin_o, int_pin_oe, cfg_level;
    int pulse_cnt, last_low, last_high, n_errors, n_checks, p0;
    // Row: class, wake, enable, fail, forcing mask, pulse expected
    typedef struct {logic c; logic [15:0] w, e, f, m; int p;} row_t;
    row_t rows [5] = '{
        '{1'b0, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 1},
        '{1'b0, 16'h0002, 16'h0000, 16'h0000, 16'h0000, 0},
        '{1'b0, 16'h0000, 16'hFFFF, 16'h0001, 16'h0000, 0},
        '{1'b1, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 1},
        '{1'b1, 16'h0000, 16'h0000, 16'h0010, 16'h0010, 0}};

    sbc_interrupt_signalling #(.PULSE_CYC(PC), .GAP_CYC(GC), .CFG_FILT_CYC(FC)) dut (
        .clk(clk), .rst_n(rst_n), .clk_en(1'b1), .mode(mode), .stop_cmd(stop_cmd),
        .class_global(class_global), .wake_evt(wake_evt), .wake_src_en(wake_src_en),
        .fail_evt(fail_evt), .fail_forcing_mask(fail_forcing_mask), .pin_level_in(pin_level_in),
        .wake_clr(wake_clr), .fail_clr(fail_clr), .wake_status(wake_status), .fail_status(fail_status),
        .pin_level_status(pin_level_status), .int_pin_i(int_wire), .int_pin_o(int_pin_o),
        .int_pin_oe(int_pin_oe), .cfg_level(cfg_level));
    host_side host (
        .clk(clk), .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe), .strap_lvl(strap_lvl),
        .strap_en(strap_en), .int_wire(int_wire), .pulse_cnt(pulse_cnt), .last_low(last_low),
        .last_high(last_high));

    // Clock at 25 MHz
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic wrap_up;
        if (n_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: bit got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: vector got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            n_errors++;
            $display("Error at %0t: count got %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One-cycle wake and failure event pulse, both sampled at the same edge
    task automatic wake_pulse(input logic [15:0] v, input logic [15:0] f);
        @(posedge clk);
        wake_evt <= v;
        fail_evt <= f;
        @(posedge clk);
        wake_evt <= 16'h0000;
        fail_evt <= 16'h0000;
    endtask
    // Host read-and-clear of every status bit
    task automatic clear_all;
        @(posedge clk);
        wake_clr <= 16'hFFFF;
        fail_clr <= 16'hFFFF;
        @(posedge clk);
        wake_clr <= 16'h0000;
        fail_clr <= 16'h0000;
    endtask

    // Watchdog sized well beyond the planned sequence
    initial begin
        cyc(3000);
        n_errors++;
        $display("Error at %0t: timeout", $time);
        wrap_up();
    end

    initial begin
        n_errors = 0;
        n_checks = 0;
        rst_n = 1'b0;
        mode = irq_sig_pkg::MODE_NORMAL;
        {stop_cmd, class_global, strap_lvl, strap_en} = 4'h0;
        {wake_evt, wake_src_en, fail_evt, fail_forcing_mask, wake_clr, fail_clr} = '0;
        {acc_w, acc_f} = '0;
        pin_level_in = 8'h00;
        cyc(10);
        chk_bit(int_pin_o, 1'b1);
        chk_vec(wake_status, 16'h0000);
        chk_bit(cfg_level, 1'b0);
        rst_n <= 1'b1;
        cyc(2);
        // Table of source selection cases
        foreach (rows[i]) begin
            p0 = pulse_cnt;
            class_global <= rows[i].c;
            wake_src_en <= rows[i].e;
            fail_forcing_mask <= rows[i].m;
            wake_pulse(rows[i].w, rows[i].f);
            // Events that raise no pulse stay hidden until the next falling edge
            acc_w = acc_w | rows[i].w;
            acc_f = acc_f | rows[i].f;
            cyc(PC + GC + 4);
            chk_cnt(pulse_cnt - p0, rows[i].p);
            if (rows[i].p == 1) begin
                chk_vec(wake_status, acc_w);
                chk_vec(fail_status, acc_f);
                {acc_w, acc_f} = '0;
            end
            clear_all();
        end
        // Event during a pulse is held and sent after the gap
        class_global <= 1'b0;
        wake_src_en <= 16'h0003;
        p0 = pulse_cnt;
        wake_pulse(16'h0001, 16'h0000);
        cyc(4);
        wake_pulse(16'h0002, 16'h0000);
        cyc(2 * (PC + GC) + 4);
        chk_cnt(pulse_cnt - p0, 2);
        chk_cnt(last_low, PC);
        chk_bit(last_high >= GC, 1'b1);
        chk_vec(wake_status, 16'h0003);
        // Stop entry with wake status left set
        p0 = pulse_cnt;
        @(posedge clk);
        mode <= irq_sig_pkg::MODE_STOP;
        stop_cmd <= 1'b1;
        @(posedge clk);
        stop_cmd <= 1'b0;
        cyc(PC + GC + 4);
        chk_cnt(pulse_cnt - p0, 1);
        chk_vec(wake_status, 16'h0003);
        clear_all();
        cyc(2);
        chk_vec(wake_status, 16'h0000);
        // Pin levels shown live and never interrupt
        p0 = pulse_cnt;
        pin_level_in <= 8'hA5;
        cyc(4);
        chk_vec({8'h00, pin_level_status}, 16'h00A5);
        chk_cnt(pulse_cnt - p0, 0);
        // Init: pin is an input with a filtered strap sample
        mode <= irq_sig_pkg::MODE_INIT;
        strap_lvl <= 1'b1;
        cyc(2);
        chk_bit(int_pin_oe, 1'b0);
        wake_pulse(16'h0001, 16'h0000);
        strap_en <= 1'b1;
        cyc(1);
        strap_en <= 1'b0;
        cyc(10);
        chk_bit(cfg_level, 1'b0);
        strap_en <= 1'b1;
        cyc(FC + 8);
        chk_bit(cfg_level, 1'b1);
        chk_cnt(pulse_cnt - p0, 0);
        wrap_up();
    end
endmodule // sbc_interrupt_signalling_tb
`default_nettype wire
